/* spio_pkg.sv */
package spio_pkg;
    localparam int unsigned SPIO_WIDTH       = 16;
    localparam int unsigned SPIO_ADDR_W      = 4;
    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [SPIO_ADDR_W-1:0] SPIO_OFS_DIR    = 4'h0;
    localparam logic [SPIO_ADDR_W-1:0] SPIO_OFS_LEVEL  = 4'h4;
    localparam logic [SPIO_ADDR_W-1:0] SPIO_OFS_LATCH  = 4'h8;
    localparam logic [SPIO_ADDR_W-1:0] SPIO_OFS_ANALOG = 4'hc;
    // ****************************************
    // reset values and unmapped read value
    // ****************************************
    localparam logic [31:0] SPIO_RST_DIR    = 32'hffff_ffff;
    localparam logic [31:0] SPIO_RST_LATCH  = 32'h0000_0000;
    localparam logic [31:0] SPIO_RST_ANALOG = 32'h0000_0000;
    localparam logic [31:0] SPIO_UNMAPPED   = 32'h0000_0000;
    // ****************************************
    // bus slave states
    // ****************************************
    typedef enum logic [1:0] {
        SPIO_IDLE = 2'b01,
        SPIO_DONE = 2'b10
    } spio_bus_st_t;
endpackage

/* spio_pad_mux.sv */
`timescale 1ns/100ps
// ****************************************
// per-pad output ownership
// ****************************************
module spio_pad_mux #(
    parameter int unsigned WIDTH = 16
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_dir,
    input  wire logic [WIDTH-1:0] i_latch,
    input  wire logic [WIDTH-1:0] i_impl,
    input  wire logic [WIDTH-1:0] i_per_en,
    input  wire logic [WIDTH-1:0] i_per_drive,
    input  wire logic [WIDTH-1:0] i_per_out,
    output logic      [WIDTH-1:0] o_pad_out,
    output logic      [WIDTH-1:0] o_pad_oe_n
);
    logic [WIDTH-1:0] per_own;
    // peripheral owns only when enabled and driving; input-only users never drive
    assign per_own = i_per_en & i_per_drive & i_impl;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_pad_out  <= '0;
            o_pad_oe_n <= '1;
        end else begin
            o_pad_out  <= (per_own & i_per_out) | (~per_own & i_latch & i_impl);
            o_pad_oe_n <= ~per_own & (i_dir | ~i_impl);
        end
    end
endmodule

/* spio_port.sv */
`timescale 1ns/100ps
// ****************************************
// shared parallel io port with avalon slave
// ****************************************
module spio_port
    import spio_pkg::*;
#(
    parameter int unsigned               WIDTH    = spio_pkg::SPIO_WIDTH,
    parameter logic [WIDTH-1:0]          IMPL_MSK = '1
) (
    input  wire logic                              i_clk,
    input  wire logic                              i_rst,
    input  wire logic [spio_pkg::SPIO_ADDR_W-1:0]  i_address,
    input  wire logic                              i_read,
    input  wire logic                              i_write,
    input  wire logic [31:0]                       i_writedata,
    input  wire logic [3:0]                        i_byteenable,
    output logic      [31:0]                       o_readdata,
    output logic                                   o_waitrequest,
    output logic      [1:0]                        o_response,
    input  wire logic [WIDTH-1:0]                  i_pad_in,
    output logic      [WIDTH-1:0]                  o_pad_out,
    output logic      [WIDTH-1:0]                  o_pad_oe_n,
    input  wire logic [WIDTH-1:0]                  i_per_en,
    input  wire logic [WIDTH-1:0]                  i_per_drive,
    input  wire logic [WIDTH-1:0]                  i_per_out
);
    import spio_pkg::*;

    initial begin
        if (WIDTH < 1 || WIDTH > 32) begin
            $error("width must be 1 to 32");
        end
    end

    logic [WIDTH-1:0] dir_q;
    logic [WIDTH-1:0] latch_q;
    logic [WIDTH-1:0] analog_q;
    logic [WIDTH-1:0] sync1_q;
    logic [WIDTH-1:0] sync2_q;
    logic [WIDTH-1:0] level;
    spio_bus_st_t     st_q;
    logic             wr_go;
    logic             rd_go;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [WIDTH-1:0] merge(input logic [WIDTH-1:0] old_v,
                                               input logic [31:0]     wd,
                                               input logic [3:0]      be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        merge = (old_v & ~m[WIDTH-1:0]) | (wd[WIDTH-1:0] & m[WIDTH-1:0]);
    endfunction

    function automatic logic [31:0] widen(input logic [WIDTH-1:0] v);
        logic [31:0] r;
        r = '0;
        r[WIDTH-1:0] = v & IMPL_MSK;
        widen = r;
    endfunction

    // ****************************************
    // bus handshake, one wait state
    // ****************************************
    assign wr_go = (st_q == SPIO_IDLE) && i_write;
    assign rd_go = (st_q == SPIO_IDLE) && i_read;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q          <= SPIO_IDLE;
            o_waitrequest <= 1'b1;
        end else begin
            case (st_q)
                SPIO_IDLE: begin
                    if (i_read || i_write) begin
                        st_q          <= SPIO_DONE;
                        o_waitrequest <= 1'b0;
                    end
                end
                SPIO_DONE: begin
                    st_q          <= SPIO_IDLE;
                    o_waitrequest <= 1'b1;
                end
                default: begin
                    st_q          <= SPIO_IDLE;
                    o_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // ****************************************
    // direction register
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            dir_q <= SPIO_RST_DIR[WIDTH-1:0];
        end else if (wr_go && i_address == SPIO_OFS_DIR) begin
            dir_q <= merge(dir_q, i_writedata, i_byteenable) & IMPL_MSK;
        end
    end

    // ****************************************
    // output latch, written from either offset
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            latch_q <= SPIO_RST_LATCH[WIDTH-1:0];
        end else if (wr_go && (i_address == SPIO_OFS_LATCH || i_address == SPIO_OFS_LEVEL)) begin
            latch_q <= merge(latch_q, i_writedata, i_byteenable) & IMPL_MSK;
        end
    end

    // ****************************************
    // analog select
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            analog_q <= SPIO_RST_ANALOG[WIDTH-1:0];
        end else if (wr_go && i_address == SPIO_OFS_ANALOG) begin
            analog_q <= merge(analog_q, i_writedata, i_byteenable) & IMPL_MSK;
        end
    end

    // ****************************************
    // pad input synchroniser
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= i_pad_in;
            sync2_q <= sync1_q;
        end
    end

    // level view ignores ownership, masks analog pins
    assign level = sync2_q & ~analog_q;

    // ****************************************
    // read data
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_readdata <= '0;
            o_response <= 2'b00;
        end else if (rd_go) begin
            o_response <= 2'b00;
            if (i_address == SPIO_OFS_DIR) begin
                o_readdata <= widen(dir_q);
            end else if (i_address == SPIO_OFS_LEVEL) begin
                o_readdata <= widen(level);
            end else if (i_address == SPIO_OFS_LATCH) begin
                o_readdata <= widen(latch_q);
            end else if (i_address == SPIO_OFS_ANALOG) begin
                o_readdata <= widen(analog_q);
            end else begin
                o_readdata <= SPIO_UNMAPPED;
                o_response <= 2'b10;
            end
        end else if (wr_go) begin
            o_readdata <= '0;
            if (i_address == SPIO_OFS_DIR || i_address == SPIO_OFS_LEVEL ||
                i_address == SPIO_OFS_LATCH || i_address == SPIO_OFS_ANALOG) begin
                o_response <= 2'b00;
            end else begin
                o_response <= 2'b10;
            end
        end
    end

    // ****************************************
    // pad ownership
    // ****************************************
    spio_pad_mux #(
        .WIDTH (WIDTH)
    ) u_mux (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_dir       (dir_q),
        .i_latch     (latch_q),
        .i_impl      (IMPL_MSK),
        .i_per_en    (i_per_en),
        .i_per_drive (i_per_drive),
        .i_per_out   (i_per_out),
        .o_pad_out   (o_pad_out),
        .o_pad_oe_n  (o_pad_oe_n)
    );
endmodule

/* spio_pad_model.sv */
`timescale 1ns/100ps
// ********
// pads plus outside drivers
// ********
module spio_pad_model #(
    parameter int unsigned WIDTH = 16
) (
    input  wire logic [WIDTH-1:0] i_pad_out,
    input  wire logic [WIDTH-1:0] i_pad_oe_n,
    input  wire logic [WIDTH-1:0] i_ext,
    output logic      [WIDTH-1:0] o_pad_in
);
    // driven pad reads back its own level, else outside level
    assign o_pad_in = (i_pad_out & ~i_pad_oe_n) | (i_ext & i_pad_oe_n);
endmodule

/* spio_port_monitor.sv */
`timescale 1ns/100ps
// ********
// port checker
// ********
module spio_port_monitor #(
    parameter int unsigned      WIDTH    = 16,
    parameter logic [WIDTH-1:0] IMPL_MSK = '1
) (
    input wire logic             i_clk,
    input wire logic             i_rst,
    input wire logic [3:0]       i_address,
    input wire logic             i_read,
    input wire logic             i_write,
    input wire logic [31:0]      o_readdata,
    input wire logic             o_waitrequest,
    input wire logic [1:0]       o_response,
    input wire logic [WIDTH-1:0] o_pad_out,
    input wire logic [WIDTH-1:0] o_pad_oe_n,
    input wire logic [WIDTH-1:0] i_per_en,
    input wire logic [WIDTH-1:0] i_per_drive,
    input wire logic [WIDTH-1:0] i_per_out
);
    logic [WIDTH-1:0] own;
    logic             req;
    logic             bad;
    assign own = i_per_en & i_per_drive & IMPL_MSK;
    assign req = i_read | i_write;
    assign bad = i_address[1:0] != 2'b00;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_take; req && o_waitrequest; endsequence
    sequence s_done; !o_waitrequest ##1 o_waitrequest; endsequence
    a_one_wait: assert property (s_take |=> s_done) else $error("wait cycle wrong");
    a_idle_hold: assert property (!req && o_waitrequest |=> o_waitrequest) else $error("spurious answer");
    a_resp_code: assert property (req && !o_waitrequest |-> o_response == (bad ? 2'b10 : 2'b00))
        else $error("response code wrong");
    a_bad_zero: assert property (i_read && !o_waitrequest && bad |-> o_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_own_data: assert property (1'b1 |=> ((o_pad_out ^ $past(i_per_out)) & $past(own)) == '0)
        else $error("peripheral data not on pad");
    a_own_oe: assert property (1'b1 |=> (o_pad_oe_n & $past(own)) == '0)
        else $error("peripheral not driving pad");
    a_reset_state: assert property ($past(i_rst) |-> o_pad_oe_n == '1 && o_waitrequest)
        else $error("reset state wrong");
    a_unimpl_oe: assert property ((o_pad_oe_n | IMPL_MSK) == '1)
        else $error("unimplemented pin driven");
endmodule
bind spio_port spio_port_monitor #(.WIDTH(WIDTH), .IMPL_MSK(IMPL_MSK)) u_mon (.i_clk(i_clk), .i_rst(i_rst),
    .i_address(i_address), .i_read(i_read), .i_write(i_write), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .o_response(o_response), .o_pad_out(o_pad_out),
    .o_pad_oe_n(o_pad_oe_n), .i_per_en(i_per_en), .i_per_drive(i_per_drive), .i_per_out(i_per_out));

/* test_shared_parallel_io_port.sv */
`timescale 1ns/100ps
// ********
// port bench
// ********
module test_shared_parallel_io_port;
    import spio_pkg::*;
    logic        i_clk, i_rst, i_read, i_write;
    logic [3:0]  i_address;
    logic [31:0] i_writedata, o_readdata, rd;
    logic        o_waitrequest;
    logic [1:0]  o_response, rsp;
    logic [15:0] pad_in, pad_out, oe_n, per_en, per_drive, per_out, ext;
    int          n_mismatch, n_compared;
    spio_port #(.WIDTH(16), .IMPL_MSK(16'h7fff)) u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_address(i_address),
        .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(4'hf),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_response(o_response), .i_pad_in(pad_in),
        .o_pad_out(pad_out), .o_pad_oe_n(oe_n), .i_per_en(per_en), .i_per_drive(per_drive), .i_per_out(per_out));
    spio_pad_model #(.WIDTH(16)) u_pads (.i_pad_out(pad_out), .i_pad_oe_n(oe_n), .i_ext(ext), .o_pad_in(pad_in));
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge i_clk);
        i_address <= a; i_write <= w; i_read <= !w; i_writedata <= d;
        do begin
            @(posedge i_clk);
            k++;
        end while (o_waitrequest !== 1'b0 && k < 20);
        if (o_waitrequest !== 1'b0) begin
            n_mismatch++;
            give_verdict();
        end
        rd = o_readdata;
        rsp = o_response;
        i_read <= 1'b0; i_write <= 1'b0;
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    task automatic t_reset;
        rdchk(SPIO_OFS_DIR, 32'h0000_7fff, "dir reset");
        rdchk(SPIO_OFS_LATCH, 32'h0, "latch reset");
        chk("oe reset", {16'h0, 16'hffff}, {16'h0, oe_n});
        $display("test reset done");
    endtask
    task automatic t_latch;
        bus(1'b1, SPIO_OFS_LATCH, 32'hffff_a5c3);
        rdchk(SPIO_OFS_LATCH, 32'h0000_25c3, "latch");
        bus(1'b1, SPIO_OFS_DIR, 32'h0);
        repeat (3) @(posedge i_clk);
        chk("pad out", {16'h0, 16'h25c3}, {16'h0, pad_out});
        chk("pad oe", {16'h0, 16'h8000}, {16'h0, oe_n});
        $display("test latch done");
    endtask
    task automatic t_level;
        bus(1'b1, SPIO_OFS_DIR, 32'hffff);
        bus(1'b1, SPIO_OFS_LEVEL, 32'h00ff);
        repeat (3) @(posedge i_clk);
        rdchk(SPIO_OFS_LEVEL, 32'h0000_1234, "level");
        rdchk(SPIO_OFS_LATCH, 32'h0000_00ff, "latch via level");
        bus(1'b1, SPIO_OFS_ANALOG, 32'h0004);
        repeat (3) @(posedge i_clk);
        rdchk(SPIO_OFS_LEVEL, 32'h0000_1230, "analog level");
        bus(1'b1, SPIO_OFS_ANALOG, 32'h0);
        $display("test level done");
    endtask
    task automatic t_periph;
        bus(1'b1, SPIO_OFS_DIR, 32'h0);
        per_en <= 16'hffff; per_drive <= 16'h000f; per_out <= 16'h000a;
        repeat (3) @(posedge i_clk);
        chk("shared out", {16'h0, 16'h00fa}, {16'h0, pad_out});
        chk("shared oe", {16'h0, 16'h8000}, {16'h0, oe_n});
        bus(1'b1, SPIO_OFS_DIR, 32'hffff);
        repeat (3) @(posedge i_clk);
        chk("owned oe", {16'h0, 16'hfff0}, {16'h0, oe_n});
        rdchk(SPIO_OFS_LEVEL, 32'h0000_123a, "owned level");
        per_drive <= 16'h0;
        repeat (3) @(posedge i_clk);
        chk("input only oe", {16'h0, 16'hffff}, {16'h0, oe_n});
        per_en <= 16'h0;
        $display("test peripheral done");
    endtask
    task automatic t_unmapped;
        bus(1'b1, 4'h2, 32'h0);
        chk("bad write resp", 32'h2, {30'h0, rsp});
        bus(1'b0, 4'h2, 32'h0);
        chk("bad read resp", 32'h2, {30'h0, rsp});
        chk("bad read data", 32'h0, rd);
        rdchk(SPIO_OFS_DIR, 32'h0000_7fff, "dir kept");
        $display("test unmapped done");
    endtask
    initial begin
        i_rst = 1'b1; i_read = 1'b0; i_write = 1'b0; i_address = 4'h0; i_writedata = 32'h0;
        per_en = 16'h0; per_drive = 16'h0; per_out = 16'h0; ext = 16'h1234;
        n_mismatch = 0; n_compared = 0;
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        t_reset();
        t_latch();
        t_level();
        t_periph();
        t_unmapped();
        give_verdict();
    end
endmodule
